// ===== logic/dctl_consts.svh
/*
 * Offsets, reset values and timing counts of the distributed-clock time loop.
 * Assumes byte-wide register accesses with 12-bit byte addresses.
 */
`ifndef DCTL_CONSTS_SVH
`define DCTL_CONSTS_SVH

// register byte addresses
`define DCTL_ADDR_RCV_PORT0 12'h900
`define DCTL_ADDR_SYSTIME 12'h910
`define DCTL_ADDR_SYSTIME_TOP 12'h913
`define DCTL_ADDR_RCV_EPU 12'h918
`define DCTL_ADDR_OFFSET 12'h920
`define DCTL_ADDR_DELAY 12'h928
`define DCTL_ADDR_DIFF 12'h92c
`define DCTL_ADDR_SPD_START 12'h930
`define DCTL_ADDR_SPD_START_HI 12'h931
`define DCTL_ADDR_SPD_DEV 12'h932
`define DCTL_ADDR_TDF_DEPTH 12'h934
`define DCTL_ADDR_SDF_DEPTH 12'h935
`define DCTL_ADDR_CYC_CTRL 12'h980
`define DCTL_ADDR_SYNC_ACT 12'h981
`define DCTL_ADDR_CAP0_POS 12'h9b0

// field positions
`define DCTL_CYC_SYNC_BIT 0
`define DCTL_CYC_CAP0_BIT 4
`define DCTL_CYC_CAP1_BIT 5

// reset values and limits
`define DCTL_SPD_START_RESET 15'h1000
`define DCTL_SPD_START_MIN 15'h0080
`define DCTL_SPD_START_MAX 15'h3fff
`define DCTL_SPD_DEV_MARGIN 16'h007f

// timing: local time advances by the clock period in ns each cycle
`define DCTL_CLK_PERIOD_NS 8
`define DCTL_STEP_NS 64'(`DCTL_CLK_PERIOD_NS)

`endif

// ===== logic/dctl_pkg.sv
/*
 * Types of the distributed-clock time loop: byte accesses, answers, frame marks, ownership.
 * Assumes the constants header is included by the design file.
 */
package dctl_pkg;
	// one byte access from either side
	typedef struct packed {
		logic req;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} dctl_acc_t;
	// read answer, one cycle after the request
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} dctl_ans_t;
	// one-cycle frame marks from the network receive path
	typedef struct packed {
		logic preamble;
		logic sof;
		logic eof;
	} dctl_frame_t;
	// ownership and activation outputs
	typedef struct packed {
		logic sync_host;
		logic cap0_host;
		logic cap1_host;
		logic sync_active;
		logic sync_pulse_zero_en;
	} dctl_own_t;
endpackage : dctl_pkg

// ===== logic/dctl_time_loop.sv
/*
 * Distributed-clock time loop: local system time, offset, delay, difference filter,
 * speed counter, cyclic unit ownership and the first two sync-out activation bits.
 * Assumes byte accesses from the network side and the host side on clk_sys, frame
 * marks as one-cycle pulses on clk_sys, and a capture pin from outside the clock domain.
 */
`include "dctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module dctl_time_loop #(
	parameter logic [14:0] SPD_START_RESET = `DCTL_SPD_START_RESET
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire dctl_pkg::dctl_acc_t net_acc,
	input wire dctl_pkg::dctl_acc_t host_acc,
	input wire dctl_pkg::dctl_frame_t net_frame,
	input wire logic host_time_ctrl_cfg,
	input wire logic cap0_pin,
	output dctl_pkg::dctl_ans_t net_ans,
	output dctl_pkg::dctl_ans_t host_ans,
	output dctl_pkg::dctl_own_t own,
	output logic [63:0] sys_time
);
	import dctl_pkg::*;

	logic host_ctrl;
	logic cfg_taken;
	logic [63:0] local_time;
	logic [63:0] offset;
	logic [31:0] delay;
	logic [63:0] net_snap;
	logic [63:0] host_snap;
	logic [63:0] pre_time;
	logic [63:0] rcv_epu;
	logic rcv_pend;
	logic [31:0] net_wbuf;
	logic net_time_wr;
	logic [23:0] host_wbuf;
	logic cap0_s1, cap0_s2, cap0_d;
	logic [63:0] cap0_time;
	logic cmp_valid;
	logic signed [31:0] cmp_diff;
	logic signed [31:0] mean;
	logic signed [15:0] dev;
	logic [14:0] spd_start;
	logic [3:0] tdf_depth;
	logic [3:0] sdf_depth;
	logic [15:0] sdf_cnt;
	logic [14:0] spd_cnt;
	logic [7:0] cyc_ctrl;

	////////////////////////////////////////////////////////////////////////////
	// access decode

	dctl_acc_t lp_acc;
	logic lp_we;
	logic net_we, host_we;
	logic [11:0] lp_word;
	assign net_we = net_acc.req & net_acc.wr;
	assign host_we = host_acc.req & host_acc.wr;
	// only the side that owns the loop may write its registers
	assign lp_acc = host_ctrl ? host_acc : net_acc;
	assign lp_we = host_ctrl ? host_we : net_we;
	assign lp_word = {lp_acc.addr[11:3], 3'h0};

	logic wr_spd_start, wr_tdf, wr_sdf;
	assign wr_spd_start = lp_we & ((lp_acc.addr == `DCTL_ADDR_SPD_START) | (lp_acc.addr == `DCTL_ADDR_SPD_START_HI));
	assign wr_tdf = lp_we & (lp_acc.addr == `DCTL_ADDR_TDF_DEPTH);
	assign wr_sdf = lp_we & (lp_acc.addr == `DCTL_ADDR_SDF_DEPTH);

	// configuration level caught once after reset release, not in the reset branch
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			host_ctrl <= 1'b0;
			cfg_taken <= 1'b0;
		end else if (!cfg_taken) begin
			host_ctrl <= host_time_ctrl_cfg;
			cfg_taken <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// local time, system time and speed steering

	logic [15:0] dev_abs;
	logic [63:0] next_step;
	assign dev_abs = dev[15] ? 16'(-dev) : 16'(dev);
	always_comb begin
		next_step = `DCTL_STEP_NS;
		if (spd_cnt == 15'h0 && dev != 16'sh0) begin
			// one ns extra or less each speed period: faster when local lags
			next_step = dev[15] ? `DCTL_STEP_NS - 64'h1 : `DCTL_STEP_NS + 64'h1;
		end
	end

	// speed counter reloads shorter as the deviation grows
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			spd_cnt <= 15'h0;
		end else if (spd_cnt == 15'h0) begin
			spd_cnt <= spd_start - dev_abs[14:0];
		end else begin
			spd_cnt <= spd_cnt - 15'h1;
		end
	end

	// free-running local time and its corrected copy
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			local_time <= 64'h0;
			sys_time <= 64'h0;
		end else begin
			local_time <= local_time + next_step;
			sys_time <= local_time + offset;
		end
	end

	// offset and delay are byte-writable by the loop owner
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			offset <= 64'h0;
			delay <= 32'h0;
		end else if (lp_we) begin
			if (lp_word == `DCTL_ADDR_OFFSET) begin
				offset[{lp_acc.addr[2:0], 3'h0} +: 8] <= lp_acc.wdata;
			end
			if ({lp_acc.addr[11:2], 2'h0} == `DCTL_ADDR_DELAY) begin
				delay[{lp_acc.addr[1:0], 3'h0} +: 8] <= lp_acc.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// snapshots and receive time

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			net_snap <= 64'h0;
		end else if (net_frame.sof) begin
			net_snap <= sys_time + {32'h0, delay};
		end
	end

	// later host bytes come from the copy taken with byte 0, so they stay consistent
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			host_snap <= 64'h0;
		end else if (host_acc.req && !host_acc.wr && host_acc.addr == `DCTL_ADDR_SYSTIME) begin
			host_snap <= sys_time;
		end
	end

	// preamble time kept per frame, published at frame end if port 0 time was written
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pre_time <= 64'h0;
			rcv_epu <= 64'h0;
			rcv_pend <= 1'b0;
		end else begin
			if (net_frame.preamble) begin
				pre_time <= local_time;
			end
			if (net_frame.eof) begin
				rcv_pend <= 1'b0;
				if (rcv_pend) begin
					rcv_epu <= pre_time;
				end
			end else if (net_we && net_acc.addr == `DCTL_ADDR_RCV_PORT0) begin
				rcv_pend <= 1'b1;
			end
		end
	end

	// capture pin synchroniser and rising-edge time
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cap0_s1 <= 1'b0;
			cap0_s2 <= 1'b0;
			cap0_d <= 1'b0;
			cap0_time <= 64'h0;
		end else begin
			cap0_s1 <= cap0_pin;
			cap0_s2 <= cap0_s1;
			cap0_d <= cap0_s2;
			if (cap0_s2 && !cap0_d) begin
				cap0_time <= sys_time;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// time writes into the loop

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			net_wbuf <= 32'h0;
			net_time_wr <= 1'b0;
			host_wbuf <= 24'h0;
			cmp_valid <= 1'b0;
			cmp_diff <= 32'sh0;
		end else begin
			cmp_valid <= 1'b0;
			if (!host_ctrl && net_we && {net_acc.addr[11:2], 2'h0} == `DCTL_ADDR_SYSTIME) begin
				net_wbuf[{net_acc.addr[1:0], 3'h0} +: 8] <= net_acc.wdata;
				if (net_acc.addr == `DCTL_ADDR_SYSTIME) begin
					net_time_wr <= 1'b1;
				end
			end
			if (net_frame.eof) begin
				net_time_wr <= 1'b0;
				if (net_time_wr) begin
					cmp_valid <= 1'b1;
					cmp_diff <= net_snap[31:0] - net_wbuf;
				end
			end
			if (host_ctrl && host_we && {host_acc.addr[11:2], 2'h0} == `DCTL_ADDR_SYSTIME) begin
				if (host_acc.addr == `DCTL_ADDR_SYSTIME_TOP) begin
					cmp_valid <= 1'b1;
					cmp_diff <= cap0_time[31:0] - {host_acc.wdata, host_wbuf};
				end else begin
					host_wbuf[{host_acc.addr[1:0], 3'h0} +: 8] <= host_acc.wdata;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// difference filter and speed deviation

	logic signed [32:0] diff_delta;
	logic signed [32:0] diff_shift;
	logic [15:0] dev_lim;
	logic sdf_tick;
	assign diff_delta = 33'(cmp_diff) - 33'(mean);
	assign diff_shift = diff_delta >>> tdf_depth;
	assign dev_lim = {1'b0, spd_start} - `DCTL_SPD_DEV_MARGIN;
	assign sdf_tick = cmp_valid && (sdf_cnt == 16'((17'h1 << sdf_depth) - 17'h1));

	// reset writes win over a comparison in the same cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mean <= 32'sh0;
		end else if (wr_spd_start || wr_tdf) begin
			mean <= 32'sh0;
		end else if (cmp_valid) begin
			mean <= mean + diff_shift[31:0];
		end
	end

	// speed filter: deviation moves once per 2^depth comparisons
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sdf_cnt <= 16'h0;
		end else if (wr_sdf || wr_spd_start) begin
			sdf_cnt <= 16'h0;
		end else if (sdf_tick) begin
			sdf_cnt <= 16'h0;
		end else if (cmp_valid) begin
			sdf_cnt <= sdf_cnt + 16'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dev <= 16'sh0;
		end else if (wr_spd_start) begin
			dev <= 16'sh0;
		end else if (sdf_tick) begin
			// mean below zero means local lags: speed up, bounded by the start value less the deviation margin
			if (mean < 0 && !dev[15] && 16'(dev) < dev_lim) begin
				dev <= dev + 16'sh1;
			end else if (mean < 0 && dev[15]) begin
				dev <= dev + 16'sh1;
			end else if (mean > 0 && dev[15] && dev_abs < dev_lim) begin
				dev <= dev - 16'sh1;
			end else if (mean > 0 && !dev[15]) begin
				dev <= dev - 16'sh1;
			end
		end
	end

	// speed start and filter depths; out-of-range start values are clamped
	logic [14:0] next_start;
	always_comb begin
		next_start = spd_start;
		if (lp_acc.addr == `DCTL_ADDR_SPD_START) begin
			next_start[7:0] = lp_acc.wdata;
		end else begin
			next_start[14:8] = lp_acc.wdata[6:0];
		end
		if (next_start < `DCTL_SPD_START_MIN) begin
			next_start = `DCTL_SPD_START_MIN;
		end else if (next_start > `DCTL_SPD_START_MAX) begin
			next_start = `DCTL_SPD_START_MAX;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			spd_start <= SPD_START_RESET;
			tdf_depth <= 4'h0;
			sdf_depth <= 4'h0;
		end else begin
			if (wr_spd_start) begin
				spd_start <= next_start;
			end
			if (wr_tdf) begin
				tdf_depth <= lp_acc.wdata[3:0];
			end
			if (wr_sdf) begin
				sdf_depth <= lp_acc.wdata[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cyclic unit ownership and sync-out activation

	logic owner_we;
	assign owner_we = cyc_ctrl[`DCTL_CYC_SYNC_BIT] ? host_we : net_we;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cyc_ctrl <= 8'h0;
			own <= '0;
		end else begin
			if (net_we && net_acc.addr == `DCTL_ADDR_CYC_CTRL) begin
				cyc_ctrl <= net_acc.wdata & 8'h31;
			end
			own.sync_host <= cyc_ctrl[`DCTL_CYC_SYNC_BIT];
			own.cap0_host <= cyc_ctrl[`DCTL_CYC_CAP0_BIT] | host_ctrl;
			own.cap1_host <= cyc_ctrl[`DCTL_CYC_CAP1_BIT];
			if (owner_we) begin
				if ((cyc_ctrl[`DCTL_CYC_SYNC_BIT] ? host_acc.addr : net_acc.addr) == `DCTL_ADDR_SYNC_ACT) begin
					own.sync_active <= (cyc_ctrl[0] ? host_acc.wdata[0] : net_acc.wdata[0]);
					own.sync_pulse_zero_en <= (cyc_ctrl[0] ? host_acc.wdata[1] : net_acc.wdata[1]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read answers

	logic [31:0] diff_reg;
	logic [31:0] mean_abs;
	assign mean_abs = mean[31] ? 32'(-mean) : 32'(mean);
	assign diff_reg = {mean[31], mean_abs[30:0]};

	function automatic logic [7:0] rd_byte(input logic [11:0] a, input logic [63:0] st);
		logic [63:0] w;
		w = 64'h0;
		unique case ({a[11:3], 3'h0})
			`DCTL_ADDR_SYSTIME: w = st;
			`DCTL_ADDR_RCV_EPU: w = rcv_epu;
			`DCTL_ADDR_OFFSET: w = offset;
			`DCTL_ADDR_DELAY: w = {diff_reg, delay};
			`DCTL_ADDR_SPD_START: w = {16'h0, 4'h0, sdf_depth, 4'h0, tdf_depth, dev, 1'b0, spd_start};
			`DCTL_ADDR_CYC_CTRL: w = {48'h0, 6'h0, own.sync_pulse_zero_en, own.sync_active,
				cyc_ctrl[7:5], cyc_ctrl[4] | host_ctrl, cyc_ctrl[3:0]};
			`DCTL_ADDR_CAP0_POS: w = cap0_time;
			default: w = 64'h0;
		endcase
		w = w >> {a[2:0], 3'h0};
		return w[7:0];
	endfunction : rd_byte

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			net_ans <= '0;
			host_ans <= '0;
		end else begin
			net_ans.valid <= net_acc.req & ~net_acc.wr;
			net_ans.rdata <= rd_byte(net_acc.addr, net_snap);
			host_ans.valid <= host_acc.req & ~host_acc.wr;
			host_ans.rdata <= rd_byte(host_acc.addr,
				(host_acc.addr == `DCTL_ADDR_SYSTIME) ? sys_time : host_snap);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_net_time_wr;
		!host_ctrl && net_we && net_acc.addr == `DCTL_ADDR_SYSTIME && !net_frame.eof;
	endsequence
	sequence s_frame_end;
		net_frame.eof;
	endsequence
	// the frame stays open for 1 to 24 cycles after the write; a bounded range keeps tools fast
	sequence s_frame_open;
		(!net_frame.eof) throughout (1'b1 ##[0:23] 1'b1);
	endsequence

	AST_NET_SNAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		net_frame.sof |=> net_snap == $past(sys_time) + {32'h0, $past(delay)})
		else $error("network snapshot wrong");
	AST_HOST_SNAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		host_acc.req && !host_acc.wr && host_acc.addr == `DCTL_ADDR_SYSTIME |=> host_snap == $past(sys_time))
		else $error("host snapshot wrong");
	AST_NET_CMP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_net_time_wr ##1 s_frame_open ##1 s_frame_end |=> cmp_valid)
		else $error("network time write not compared");
	AST_HOST_CMP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		host_ctrl && host_we && host_acc.addr == `DCTL_ADDR_SYSTIME_TOP
		|=> cmp_valid && cmp_diff == $past(cap0_time[31:0]) - {$past(host_acc.wdata), $past(host_wbuf)})
		else $error("host time write not compared");
	AST_NET_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_b)
		host_ctrl && net_we && !host_we |=> $stable(offset) && $stable(delay) && $stable(spd_start))
		else $error("network wrote loop while host-controlled");
	AST_START_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_spd_start |=> spd_start >= `DCTL_SPD_START_MIN && spd_start <= `DCTL_SPD_START_MAX)
		else $error("speed start out of range");
	AST_SPD_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_spd_start |=> mean == 32'sh0 && dev == 16'sh0 && sdf_cnt == 16'h0)
		else $error("speed start write did not clear");
	AST_DEV_LIMIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!$past(wr_spd_start) |-> dev_abs <= dev_lim || $past(dev_abs) == dev_abs)
		else $error("deviation beyond limit");
	AST_CYC_NET_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
		host_we && !net_we |=> $stable(cyc_ctrl))
		else $error("host changed cyclic control");
	AST_CAP0_HOST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		host_ctrl ##1 host_ctrl |-> own.cap0_host)
		else $error("capture 0 not host-owned");
	AST_SYNC_OWNER: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cyc_ctrl[0] && net_we && !host_we |=> $stable(own.sync_active) && $stable(own.sync_pulse_zero_en))
		else $error("non-owner changed sync activation");
	AST_RCV_EPU: assert property (@(posedge clk_sys) disable iff (!rst_b)
		net_frame.eof && rcv_pend |=> rcv_epu == $past(pre_time))
		else $error("receive time not recorded");
endmodule : dctl_time_loop

`default_nettype wire

// ===== tb/dctl_far_side.sv
/*
 * Far-side model of the time loop: network frame marks and the capture-0 pin.
 * Assumes the bench calls its tasks by hierarchical name while clk_sys runs.
 */
`timescale 1ns/1ns
`default_nettype none

module dctl_far_side (
	input wire logic clk_sys,
	output dctl_pkg::dctl_frame_t net_frame,
	output logic cap0_pin
);
	import dctl_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// idle line levels, the pin rests low between captures
	initial begin
		net_frame = '0;
		cap0_pin = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// preamble then start-of-frame delimiter, one cycle each
	task frame_start;
		@(posedge clk_sys);
		net_frame.preamble <= 1'b1;
		@(posedge clk_sys);
		net_frame.preamble <= 1'b0;
		net_frame.sof <= 1'b1;
		@(posedge clk_sys);
		net_frame.sof <= 1'b0;
		#1;
	endtask : frame_start

	// gap lets a frame end promptly or late, like a long telegram
	task frame_end(input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		net_frame.eof <= 1'b1;
		@(posedge clk_sys);
		net_frame.eof <= 1'b0;
	endtask : frame_end

	// pin is held long enough to pass the two-stage synchroniser
	task capture(input int hold);
		@(posedge clk_sys);
		cap0_pin <= 1'b1;
		repeat (hold) @(posedge clk_sys);
		cap0_pin <= 1'b0;
	endtask : capture
endmodule : dctl_far_side

`default_nettype wire

// ===== tb/dctl_time_loop_bench.sv
/*
 * Self-checking bench of the time loop: byte accesses from both sides, frames and captures
 * from the far-side model, random values from a fixed seed.
 * Assumes the design files and the far-side model are compiled first.
 */
`include "dctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module dctl_time_loop_bench;
	import dctl_pkg::*;
	localparam logic NET = 1'b0;
	localparam logic HOST = 1'b1;
	localparam logic RD = 1'b0;
	localparam logic WR = 1'b1;
	logic clk_sys;
	logic rst_b;
	logic host_time_ctrl_cfg;
	dctl_acc_t net_acc;
	dctl_acc_t host_acc;
	dctl_frame_t net_frame;
	logic cap0_pin;
	dctl_ans_t net_ans;
	dctl_ans_t host_ans;
	dctl_own_t own;
	logic [63:0] sys_time;
	int n_fail = 0;
	int n_tests = 0;
	longint cyc = 0;
	longint c0;
	logic [63:0] off;
	logic [63:0] st;
	logic [31:0] w;
	logic [31:0] dly;
	logic [7:0] b;
	logic [7:0] r;
	logic [11:0] rst_addr[5] = '{12'h930, 12'h931, 12'h981, 12'h980, 12'h9ff};
	logic [7:0] rst_exp[5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
	logic [7:0] clamp_wr[2] = '{8'h00, 8'hff};
	logic [15:0] clamp_exp[2] = '{16'h0080, 16'h3fff};

	dctl_time_loop i_dctl_time_loop (.clk_sys(clk_sys), .rst_b(rst_b), .net_acc(net_acc),
		.host_acc(host_acc), .net_frame(net_frame), .host_time_ctrl_cfg(host_time_ctrl_cfg),
		.cap0_pin(cap0_pin), .net_ans(net_ans), .host_ans(host_ans), .own(own), .sys_time(sys_time));
	dctl_far_side i_dctl_far_side (.clk_sys(clk_sys), .net_frame(net_frame), .cap0_pin(cap0_pin));

	////////////////////////////////////////////////////////////////////////////
	// 125 MHz clock and an edge counter for exact time expectations
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// captured times land a few cycles off the bench's own sample
	function automatic logic near(input logic [31:0] a, input logic [31:0] e);
		return (a - e < 32'd64) || (e - a < 32'd64);
	endfunction : near

	// one byte access; request held for exactly the taking edge
	task acc(input logic h, input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		if (h) host_acc <= '{1'b1, wr, a, d};
		else net_acc <= '{1'b1, wr, a, d};
		@(posedge clk_sys);
		host_acc.req <= 1'b0;
		net_acc.req <= 1'b0;
		#1;
		r = h ? host_ans.rdata : net_ans.rdata;
		if (!wr) chk(h ? host_ans.valid : net_ans.valid, 1'b1);
	endtask : acc

	// little-endian four-byte transfers
	task wr32(input logic h, input logic [11:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++) acc(h, WR, a + 12'(i), d[8*i +: 8]);
	endtask : wr32

	task rd32(input logic h, input logic [11:0] a);
		for (int i = 0; i < 4; i++) begin
			acc(h, RD, a + 12'(i), 8'h00);
			w[8*i +: 8] = r;
		end
	endtask : rd32

	task reset_dut(input logic host_ctrl);
		@(posedge clk_sys);
		host_time_ctrl_cfg <= host_ctrl;
		rst_b <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask : reset_dut

	task final_report;
		if (n_fail == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////
	// main sequence, network-controlled first, then host-controlled
	initial begin
		net_acc = '0;
		host_acc = '0;
		rst_b = 1'b0;
		host_time_ctrl_cfg = 1'b0;
		void'($urandom(32'h9ce6c1c6));
		reset_dut(1'b0);
		foreach (rst_addr[i]) begin
			acc(NET, RD, rst_addr[i], 8'h00);
			chk(r, rst_exp[i]);
		end
		// offset lands whole in system time, ticks of 8 ns while deviation is zero
		off = {$urandom, $urandom};
		@(posedge clk_sys);
		#1;
		st = sys_time;
		c0 = cyc;
		wr32(NET, `DCTL_ADDR_OFFSET, off[31:0]);
		wr32(NET, `DCTL_ADDR_OFFSET + 12'h4, off[63:32]);
		repeat (2) @(posedge clk_sys);
		#1;
		chk(sys_time, st + off + `DCTL_STEP_NS * 64'(cyc - c0));
		acc(NET, WR, `DCTL_ADDR_SPD_START, 8'h00);
		dly = $urandom & 32'hffff;
		wr32(NET, `DCTL_ADDR_DELAY, dly);
		// two frames: local ahead then behind, each cleared a different way
		for (int k = 0; k < 2; k++) begin
			i_dctl_far_side.frame_start();
			st = sys_time;
			acc(NET, WR, `DCTL_ADDR_RCV_PORT0, 8'h00);
			rd32(NET, `DCTL_ADDR_SYSTIME);
			chk(near(w, st[31:0] + dly), 1'b1);
			wr32(NET, `DCTL_ADDR_SYSTIME, k ? w + 32'd100 : w - 32'd100);
			i_dctl_far_side.frame_end($urandom_range(8, 0));
			repeat (3) @(posedge clk_sys);
			rd32(NET, `DCTL_ADDR_DIFF);
			chk(w, k ? 32'h80000064 : 32'h00000064);
			rd32(NET, `DCTL_ADDR_RCV_EPU);
			chk(near(w, st[31:0] - off[31:0]), 1'b1);
			acc(NET, WR, k ? `DCTL_ADDR_TDF_DEPTH : `DCTL_ADDR_SPD_START, k ? 8'hff : 8'h00);
			rd32(NET, `DCTL_ADDR_DIFF);
			chk(w, 32'h0);
			rd32(NET, `DCTL_ADDR_SPD_DEV);
			if (k) chk(w[23:16], 8'h0f);
			else chk(w[15:0], 16'h0000);
		end
		acc(NET, WR, `DCTL_ADDR_SDF_DEPTH, 8'hff);
		acc(NET, RD, `DCTL_ADDR_SDF_DEPTH, 8'h00);
		chk(r, 8'h0f);
		// each byte write clamps the start value into its legal range
		foreach (clamp_wr[i]) begin
			acc(NET, WR, `DCTL_ADDR_SPD_START_HI, clamp_wr[i]);
			rd32(NET, `DCTL_ADDR_SPD_START);
			chk(w[15:0], clamp_exp[i]);
		end
		// ownership register belongs to the network side only
		acc(HOST, WR, `DCTL_ADDR_CYC_CTRL, 8'h31);
		acc(NET, RD, `DCTL_ADDR_CYC_CTRL, 8'h00);
		chk(r, 8'h00);
		b = 8'($urandom);
		acc(NET, WR, `DCTL_ADDR_CYC_CTRL, b);
		acc(NET, RD, `DCTL_ADDR_CYC_CTRL, 8'h00);
		chk(r, b & 8'h31);
		chk({own.sync_host, own.cap0_host, own.cap1_host}, {b[0], b[4], b[5]});
		// activation taken from the owner of the unit only
		for (int o = 0; o < 2; o++) begin
			acc(NET, WR, `DCTL_ADDR_CYC_CTRL, 8'(o));
			acc(!o, WR, `DCTL_ADDR_SYNC_ACT, 8'h03);
			acc(1'(o), RD, `DCTL_ADDR_SYNC_ACT, 8'h00);
			chk({r[1:0], own.sync_active, own.sync_pulse_zero_en}, 4'h0);
			acc(1'(o), WR, `DCTL_ADDR_SYNC_ACT, 8'h03);
			acc(1'(o), RD, `DCTL_ADDR_SYNC_ACT, 8'h00);
			chk({r[1:0], own.sync_active, own.sync_pulse_zero_en}, 4'hf);
			acc(1'(o), WR, `DCTL_ADDR_SYNC_ACT, 8'h00);
		end
		// upper bytes come from the snapshot taken by the lowest byte
		acc(HOST, RD, `DCTL_ADDR_SYSTIME, 8'h00);
		st = sys_time;
		w[7:0] = r;
		repeat (40) @(posedge clk_sys);
		for (int i = 1; i < 4; i++) begin
			acc(HOST, RD, `DCTL_ADDR_SYSTIME + 12'(i), 8'h00);
			w[8*i +: 8] = r;
		end
		chk(near(w, st[31:0]), 1'b1);
		// host-controlled system time
		reset_dut(1'b1);
		acc(NET, RD, `DCTL_ADDR_CYC_CTRL, 8'h00);
		chk({r, own.cap0_host}, {8'h10, 1'b1});
		acc(NET, WR, `DCTL_ADDR_OFFSET, 8'h5a);
		acc(HOST, WR, `DCTL_ADDR_DELAY, 8'ha5);
		acc(HOST, RD, `DCTL_ADDR_OFFSET, 8'h00);
		b = r;
		acc(HOST, RD, `DCTL_ADDR_DELAY, 8'h00);
		chk({b, r}, 16'h00a5);
		st = sys_time;
		i_dctl_far_side.capture(6);
		rd32(HOST, `DCTL_ADDR_CAP0_POS);
		chk(near(w, st[31:0]), 1'b1);
		dly = w;
		wr32(HOST, `DCTL_ADDR_SYSTIME, dly - 32'd100);
		repeat (3) @(posedge clk_sys);
		rd32(HOST, `DCTL_ADDR_DIFF);
		chk(w, 32'd100);
		// a second compare with the mean still positive steps the deviation down by one
		wr32(HOST, `DCTL_ADDR_SYSTIME, dly - 32'd100);
		repeat (3) @(posedge clk_sys);
		rd32(HOST, `DCTL_ADDR_SPD_DEV);
		chk(w[15:0], 16'hffff);
		final_report();
	end

	// the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end
endmodule : dctl_time_loop_bench

`default_nettype wire
